// >>> src/picmd_channel.sv
`timescale 1ns/10ps
// Operation
// - Output fault while invalid command bits set
// - Bad parameter check flags, uses defaults
// - Status bits 8-13, 16-31 read zero
// - Position signed, scaled, direction, offset applied
// - Velocity is counts per second
// - Latch position on configured input edges
// - Captured position zero at power-up
// - Rising latch active at power-up captures
// - Look-ahead from time value and velocity
// - Preset rise sets position to preset
// - Default preset value is zero
// - Look-ahead bit toggle samples time, computes
// - Clear-fault rise clears latched sensor fault
// - Command bits 3-31 start no action; set, they raise output fault
// - Preset acknowledge confirms preset reception
// - Setup reprogram discards preset offset
// - Look-ahead acknowledge follows command after update
// - Status bit 0 is preset acknowledge
// - Status bit 1 is look-ahead acknowledge
// - Latched sensor fault holds until cleared
module picmd_channel
	import picmd_pkg::*;
(
	input wire logic i_clock, // 50 MHz clock
	input wire logic i_rst, // Synchronous reset, high
	input wire logic i_out_valid, // New output image this cycle
	input wire logic i_out_sel, // Word index of the output image
	input wire logic [31:0] i_out_data, // Output image word
	input wire logic i_raw_valid, // New sensor reading
	input wire logic [31:0] i_raw_count, // Scaled sensor count, positive sense
	input wire logic i_sensor_fault, // Live sensor fault
	input wire logic i_latch_in, // Latch input level
	input wire logic i_setup_write, // Setup parameters reprogrammed
	input wire picmd_cfg_t i_cfg, // Setup parameters
	input wire logic i_preset_programmed, // A preset value was programmed
	input wire logic i_crc_bad, // Stored parameters failed check
	output picmd_image_t o_image // Input image for the controller
);
	// ==========================================================
	// Output image capture and edge detection
	picmd_pu_t pu_ff;
	logic [31:0] cmd_ff;
	logic [31:0] prev_cmd_ff;
	logic [31:0] time_ff;
	logic cmd_new_ff;
	logic [31:0] rise;
	logic [31:0] toggle;
	logic use_defaults;
	picmd_cfg_t cfg;

	// Register the command and time words as the controller writes them
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cmd_ff <= RST_ZERO;
			prev_cmd_ff <= RST_ZERO;
			time_ff <= RST_ZERO;
			cmd_new_ff <= 1'b0;
		end else begin
			cmd_new_ff <= 1'b0;
			if (i_out_valid && i_out_sel == OFF_CMD_WORD) begin
				prev_cmd_ff <= cmd_ff;
				cmd_ff <= i_out_data;
				cmd_new_ff <= 1'b1;
			end
			if (i_out_valid && i_out_sel == OFF_TIME_VALUE) begin
				time_ff <= i_out_data;
			end
		end
	end

	// Edges act once, only on the cycle after a new word arrived
	assign rise = cmd_new_ff ? (cmd_ff & ~prev_cmd_ff) : RST_ZERO;
	assign toggle = cmd_new_ff ? (cmd_ff ^ prev_cmd_ff) : RST_ZERO;

	// Reserved command bits alone must never start an action
	a_reserved_inert: assert property (@(posedge i_clock) disable iff (i_rst)
		(cmd_new_ff && cmd_ff[CMD_CLR_FAULT:0] == prev_cmd_ff[CMD_CLR_FAULT:0]
		&& !i_setup_write) |=> (offset_ff == $past(offset_ff) && !look_busy_ff))
		else $error("reserved command bit acted");

	// Bad parameter area falls back to the default set
	assign use_defaults = i_crc_bad;
	always_comb begin
		cfg = i_cfg;
		if (use_defaults) begin
			cfg = '0;
			cfg.latch_rise = 1'b1;
		end
		if (use_defaults || !i_preset_programmed) begin
			cfg.preset_value = DEF_PRESET;
		end
	end

	// A failed parameter check must run on the default set
	a_crc_defaults: assert property (@(posedge i_clock) disable iff (i_rst)
		i_crc_bad |-> (cfg.preset_value == DEF_PRESET && cfg.latch_rise && !cfg.fault_latch))
		else $error("defaults not used");

	// Without a programmed preset the preset target is zero
	a_default_preset: assert property (@(posedge i_clock) disable iff (i_rst)
		!i_preset_programmed |-> cfg.preset_value == DEF_PRESET)
		else $error("default preset not zero");

	// Power-up sequence: one cycle to observe the latch input after reset
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pu_ff <= PU_RESET;
		end else begin
			case (pu_ff)
				PU_RESET: pu_ff <= PU_CHECK;
				PU_CHECK: pu_ff <= PU_RUN;
				PU_RUN: pu_ff <= PU_RUN;
				default: pu_ff <= PU_RESET;
			endcase
		end
	end

	// ==========================================================
	// Position and preset offset
	logic [31:0] offset_ff;
	logic [31:0] dir_count;
	logic [31:0] position;

	assign dir_count = cfg.count_negative ? (32'h0 - i_raw_count) : i_raw_count;
	assign position = dir_count + offset_ff;

	// Offset makes the position equal the preset at the moment of the rise
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			offset_ff <= RST_ZERO;
		end else if (i_setup_write) begin
			offset_ff <= RST_ZERO;
		end else if (rise[CMD_PRESET]) begin
			offset_ff <= cfg.preset_value - dir_count;
		end
	end

	// After a preset the reported position equals the preset target
	a_preset_result: assert property (@(posedge i_clock) disable iff (i_rst)
		(rise[CMD_PRESET] && !i_setup_write) ##1 ($stable(i_raw_count) && $stable(cfg)) |->
		o_image.position == $past(cfg.preset_value))
		else $error("position not at preset");

	// ==========================================================
	// Velocity: change of position counted over a one second window
	logic [31:0] win_start_ff;
	logic [31:0] rate_ff;
	logic [25:0] win_cnt_ff;

	// A full second window trades update rate for a plain counts/second value
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			win_cnt_ff <= 26'h0;
			win_start_ff <= RST_ZERO;
			rate_ff <= RST_ZERO;
		end else if (win_cnt_ff == 26'(VEL_WINDOW_CYC - 1)) begin
			win_cnt_ff <= 26'h0;
			rate_ff <= position - win_start_ff;
			win_start_ff <= position;
		end else begin
			win_cnt_ff <= win_cnt_ff + 26'h1;
		end
	end

	// Rate stands between window ends, so the controller reads a settled value
	a_rate_holds: assert property (@(posedge i_clock) disable iff (i_rst)
		(win_cnt_ff != 26'(VEL_WINDOW_CYC - 1)) |=> rate_ff == $past(rate_ff))
		else $error("rate moved mid-window");

	// ==========================================================
	// Latch capture
	logic latch_prev_ff;
	logic [31:0] captured_ff;
	logic latch_hit;

	assign latch_hit = (cfg.latch_rise && i_latch_in && !latch_prev_ff)
		|| (cfg.latch_fall && !i_latch_in && latch_prev_ff);

	// Previous level starts low but PU_RESET blocks edges; with rising latch enabled, an input high at power-up is captured by the PU_CHECK test
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			latch_prev_ff <= 1'b0;
			captured_ff <= RST_ZERO;
		end else begin
			latch_prev_ff <= i_latch_in;
			if (pu_ff == PU_CHECK && cfg.latch_rise && i_latch_in) begin
				captured_ff <= position;
			end else if (pu_ff != PU_RESET && latch_hit) begin
				captured_ff <= position;
			end
		end
	end

	// Captured value comes out of reset as zero
	a_captured_reset: assert property (@(posedge i_clock) disable iff (i_rst)
		$fell(i_rst) |-> captured_ff == RST_ZERO)
		else $error("captured not cleared");

	// A rising-edge latch input already high after reset captures once
	a_latch_powerup: assert property (@(posedge i_clock) disable iff (i_rst)
		(pu_ff == PU_CHECK && cfg.latch_rise && i_latch_in) |=>
		captured_ff == $past(position))
		else $error("power-up capture missed");

	// ==========================================================
	// Look-ahead computation
	logic [31:0] look_ff;
	logic [31:0] last_time_ff;
	logic look_ack_ff;
	logic look_busy_ff;
	logic signed [63:0] look_prod;
	logic [31:0] dt_us;

	assign dt_us = time_ff - last_time_ff;
	// Velocity times microseconds, scaled back to counts
	assign look_prod = 64'($signed(rate_ff)) * 64'($signed({1'b0, dt_us[30:0]}));

	// Two-step: mark busy on the toggle, then compute and acknowledge together in the next cycle
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			look_ff <= RST_ZERO;
			last_time_ff <= RST_ZERO;
			look_ack_ff <= 1'b0;
			look_busy_ff <= 1'b0;
		end else if (look_busy_ff) begin
			look_ff <= position + 32'(look_prod / 64'sh000f_4240);
			look_ack_ff <= cmd_ff[CMD_LOOKAHEAD];
			last_time_ff <= time_ff; // Reference for the next interval
			look_busy_ff <= 1'b0;
		end else if (toggle[CMD_LOOKAHEAD]) begin
			look_busy_ff <= 1'b1;
		end
	end

	// A command toggle while idle always starts a computation
	a_toggle_starts: assert property (@(posedge i_clock) disable iff (i_rst)
		(toggle[CMD_LOOKAHEAD] && !look_busy_ff) |=> look_busy_ff)
		else $error("look-ahead not started");

	// The look-ahead value stands until the next computation
	a_look_holds: assert property (@(posedge i_clock) disable iff (i_rst)
		!look_busy_ff |=> look_ff == $past(look_ff))
		else $error("look-ahead moved while idle");

	// ==========================================================
	// Status flags
	logic fault_ff;
	logic preset_ack_ff;
	logic out_fault;

	assign out_fault = |(cmd_ff & ~CMD_VALID_MASK);

	// Live fault sets; latched mode holds it until the clear-command rise
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			fault_ff <= 1'b0;
		end else if (i_sensor_fault) begin
			fault_ff <= 1'b1; // Set wins over a clear in the same cycle
		end else if (!cfg.fault_latch || rise[CMD_CLR_FAULT]) begin
			fault_ff <= 1'b0;
		end
	end

	// A live fault always shows, even against a clear in the same cycle
	a_fault_sets: assert property (@(posedge i_clock) disable iff (i_rst)
		i_sensor_fault |=> fault_ff)
		else $error("sensor fault not set");

	// Without fault latching the flag follows the live fault
	a_fault_follows: assert property (@(posedge i_clock) disable iff (i_rst)
		(!cfg.fault_latch && !i_sensor_fault) |=> !fault_ff)
		else $error("unlatched fault stuck");

	// Acknowledge follows the command bit so the controller can finish
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			preset_ack_ff <= 1'b0;
		end else begin
			preset_ack_ff <= cmd_ff[CMD_PRESET];
		end
	end

	// Acknowledge drops once the controller ends the preset cycle
	a_preset_ack_drop: assert property (@(posedge i_clock) disable iff (i_rst)
		!cmd_ff[CMD_PRESET] |=> !o_image.status[ST_PRESET_ACK])
		else $error("preset acknowledge stuck");

	// ==========================================================
	// Input image assembly; unlisted status bits stay zero
	always_comb begin
		o_image = '0;
		o_image.status[ST_PRESET_ACK] = preset_ack_ff;
		o_image.status[ST_LOOK_ACK] = look_ack_ff;
		o_image.status[ST_SENSOR_FAULT] = fault_ff;
		o_image.status[ST_OUT_FAULT] = out_fault;
		o_image.status[ST_CRC_FAULT] = i_crc_bad;
		o_image.position = position;
		o_image.rate = rate_ff;
		o_image.captured = captured_ff;
		o_image.lookahead = look_ff;
	end

	// Parameter check failure is reported for as long as it lasts
	a_crc_status: assert property (@(posedge i_clock) disable iff (i_rst)
		o_image.status[ST_CRC_FAULT] == i_crc_bad)
		else $error("parameter fault flag wrong");

	// ==========================================================
	// Checks
	a_preset_ack_follow: assert property (@(posedge i_clock) disable iff (i_rst)
		cmd_ff[CMD_PRESET] |=> o_image.status[ST_PRESET_ACK])
		else $error("preset acknowledge missed");
	a_out_fault_flag: assert property (@(posedge i_clock) disable iff (i_rst)
		o_image.status[ST_OUT_FAULT] == (|cmd_ff[31:3]))
		else $error("output fault mismatch");
	a_preset_sets_pos: assert property (@(posedge i_clock) disable iff (i_rst)
		(rise[CMD_PRESET] && !i_setup_write) |=>
		offset_ff == $past(cfg.preset_value) - $past(dir_count))
		else $error("preset offset wrong");
	a_setup_clears_off: assert property (@(posedge i_clock) disable iff (i_rst)
		i_setup_write |=> offset_ff == 32'h0)
		else $error("offset not discarded");
	a_look_ack_time: assert property (@(posedge i_clock) disable iff (i_rst)
		(toggle[CMD_LOOKAHEAD] && !look_busy_ff) |=> ##1
		o_image.status[ST_LOOK_ACK] == $past(cmd_ff[CMD_LOOKAHEAD]))
		else $error("look-ahead ack late");
	a_fault_holds: assert property (@(posedge i_clock) disable iff (i_rst)
		(fault_ff && cfg.fault_latch && !rise[CMD_CLR_FAULT]) |=> fault_ff)
		else $error("latched fault dropped");
	a_fault_clears: assert property (@(posedge i_clock) disable iff (i_rst)
		(rise[CMD_CLR_FAULT] && !i_sensor_fault) |=> !fault_ff)
		else $error("fault not cleared");
	a_reserved_zero: assert property (@(posedge i_clock) disable iff (i_rst)
		o_image.status[13:8] == 6'h0 && o_image.status[31:16] == 16'h0)
		else $error("reserved status bit set");
	a_latch_capture: assert property (@(posedge i_clock) disable iff (i_rst)
		(latch_hit && pu_ff == PU_RUN) |=> captured_ff == $past(position))
		else $error("latch capture missed");
endmodule // picmd_channel

// >>> src/picmd_pkg.sv
package picmd_pkg;
	// Output image word indices per channel
	localparam logic [0:0] OFF_CMD_WORD = 1'h0;
	localparam logic [0:0] OFF_TIME_VALUE = 1'h1;
	// Command word bit positions
	localparam int CMD_PRESET = 0;
	localparam int CMD_LOOKAHEAD = 1;
	localparam int CMD_CLR_FAULT = 2;
	localparam logic [31:0] CMD_VALID_MASK = 32'h0000_0007;
	// Status word bit positions
	localparam int ST_PRESET_ACK = 0;
	localparam int ST_LOOK_ACK = 1;
	localparam int ST_SENSOR_FAULT = 7;
	localparam int ST_OUT_FAULT = 14;
	localparam int ST_CRC_FAULT = 15;
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] DEF_PRESET = 32'h0000_0000;
	// Velocity sampling window: one second of clocks at 50 MHz
	localparam int CLK_HZ = 50_000_000;
	localparam int VEL_WINDOW_MS = 1000;
	localparam int VEL_WINDOW_CYC = CLK_HZ / 1000 * VEL_WINDOW_MS;
	// Configuration bundle from the setup path
	typedef struct packed {
		logic fault_latch;
		logic count_negative;
		logic latch_rise;
		logic latch_fall;
		logic [31:0] preset_value;
	} picmd_cfg_t;
	// Input image of one channel
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] position;
		logic [31:0] rate;
		logic [31:0] captured;
		logic [31:0] lookahead;
	} picmd_image_t;
	// Gray coded power-up sequence
	typedef enum logic [1:0] {
		PU_RESET = 2'b00,
		PU_CHECK = 2'b01,
		PU_RUN = 2'b11
	} picmd_pu_t;
endpackage

// >>> dv/picmd_ctrl_model.sv
`timescale 1ns/10ps
// ==========
// Controller model: writes output image words one at a time
module picmd_ctrl_model
	import picmd_pkg::*;
(
	input wire logic i_clock, // Bench clock
	input wire logic i_ack_preset, // Preset acknowledge from status
	output logic o_valid, // Word strobe
	output logic o_sel, // Word index
	output logic [31:0] o_data // Word data
);
	logic [31:0] cmd_ff; // Last command word sent
	// Idle at time zero
	initial begin
		o_valid <= 1'b0;
		o_sel <= 1'b0;
		o_data <= 32'h0;
		cmd_ff = 32'h0;
	end
	// Data is inverted after release so a stale word is never reused
	task automatic put(input logic sel, input logic [31:0] data);
		@(posedge i_clock);
		o_valid <= 1'b1;
		o_sel <= sel;
		o_data <= data;
		if (!sel) begin
			cmd_ff = data;
		end
		@(posedge i_clock);
		o_valid <= 1'b0;
		o_data <= ~data;
	endtask
	// Raise preset, wait a bounded time for the acknowledge, then drop it
	task automatic preset(output logic got);
		got = 1'b0;
		put(1'b0, cmd_ff | 32'h1);
		for (int n = 0; n < 8 && !got; n++) begin
			@(posedge i_clock);
			#1;
			got = i_ack_preset;
		end
		put(1'b0, cmd_ff & 32'hffff_fffe);
	endtask
	// Time value first, then bit 1 set opposite to the acknowledge
	task automatic look(input logic [31:0] t, input logic ack);
		put(1'b1, t);
		put(1'b0, {cmd_ff[31:2], ~ack, cmd_ff[0]});
	endtask
endmodule // picmd_ctrl_model

// >>> dv/position_io_command_status_bench.sv
`timescale 1ns/10ps
// ==========
// Bench for one channel
module position_io_command_status_bench
	import picmd_pkg::*;
;
	logic i_clock, i_rst, i_out_valid, i_out_sel, i_latch_in, i_sensor_fault;
	logic i_setup_write, i_crc_bad, i_preset_programmed, got;
	logic [31:0] i_out_data, i_raw_count;
	picmd_cfg_t i_cfg;
	picmd_image_t o_image;
	int err_count, checks_done;
	// 50 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #10 i_clock = ~i_clock;
	end
	picmd_channel i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_out_valid(i_out_valid),
		.i_out_sel(i_out_sel), .i_out_data(i_out_data), .i_raw_valid(1'b1),
		.i_raw_count(i_raw_count), .i_sensor_fault(i_sensor_fault), .i_latch_in(i_latch_in),
		.i_setup_write(i_setup_write), .i_cfg(i_cfg), .i_preset_programmed(i_preset_programmed),
		.i_crc_bad(i_crc_bad), .o_image(o_image));
	picmd_ctrl_model i_ctrl (.i_clock(i_clock), .i_ack_preset(o_image.status[ST_PRESET_ACK]),
		.o_valid(i_out_valid), .o_sel(i_out_sel), .o_data(i_out_data));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Let the edge's updates land before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Watchdog: tests need well under a thousand cycles
	initial begin
		#100_000;
		err_count++;
		wrap_up();
	end
	// ==========
	// Tests
	initial begin
		i_rst <= 1'b1;
		i_latch_in <= 1'b1;
		i_sensor_fault <= 1'b0;
		i_setup_write <= 1'b0;
		i_crc_bad <= 1'b0;
		i_preset_programmed <= 1'b1;
		i_raw_count <= 32'h0000_0010;
		i_cfg <= '{1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0064};
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		tick(3);
		chk("captured", o_image.captured, 32'h0000_0010);
		chk("rate", o_image.rate, 32'h0);
		chk("position", o_image.position, 32'h0000_0010);
		chk("reserved", o_image.status & 32'hffff_3f00, 32'h0);
		@(posedge i_clock);
		i_latch_in <= 1'b0;
		i_raw_count <= 32'h0000_0030;
		tick(3);
		@(posedge i_clock);
		i_latch_in <= 1'b1;
		tick(4);
		chk("captured", o_image.captured, 32'h0000_0030);
		$display("latch test done");
		i_ctrl.preset(got);
		chk("preset ack", {31'h0, got}, 32'h1);
		tick(3);
		chk("position", o_image.position, 32'h0000_0064);
		chk("ack low", o_image.status & 32'h1, 32'h0);
		@(posedge i_clock);
		i_raw_count <= 32'h0000_0040;
		tick(1);
		chk("position", o_image.position, 32'h0000_0074);
		@(posedge i_clock);
		i_setup_write <= 1'b1;
		@(posedge i_clock);
		i_setup_write <= 1'b0;
		tick(2);
		chk("position", o_image.position, 32'h0000_0040);
		@(posedge i_clock);
		i_preset_programmed <= 1'b0;
		i_ctrl.preset(got);
		tick(3);
		chk("position", o_image.position, 32'h0);
		$display("preset test done");
		i_ctrl.put(1'b0, 32'h8000_0008);
		tick(3);
		chk("out fault", o_image.status & 32'h4000, 32'h4000);
		i_ctrl.put(1'b0, 32'h0);
		tick(3);
		chk("out fault", o_image.status & 32'h4000, 32'h0);
		@(posedge i_clock);
		i_sensor_fault <= 1'b1;
		@(posedge i_clock);
		i_sensor_fault <= 1'b0;
		tick(3);
		chk("sensor fault", o_image.status & 32'h80, 32'h80);
		i_ctrl.put(1'b0, 32'h4);
		tick(3);
		chk("sensor fault", o_image.status & 32'h80, 32'h0);
		i_ctrl.put(1'b0, 32'h0);
		$display("fault test done");
		i_raw_count <= 32'h0000_0070;
		for (int k = 0; k < 2; k++) begin
			i_ctrl.look(32'h0000_1000, o_image.status[ST_LOOK_ACK]);
			tick(4);
			chk("look ack", o_image.status & 32'h2, k ? 32'h0 : 32'h2);
			chk("lookahead", o_image.lookahead, 32'h0000_0030);
		end
		$display("look-ahead test done");
		// Second reset with the latch input low: nothing may be captured
		@(posedge i_clock);
		i_latch_in <= 1'b0;
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		tick(3);
		chk("captured", o_image.captured, 32'h0);
		chk("lookahead", o_image.lookahead, 32'h0);
		chk("rate", o_image.rate, 32'h0);
		chk("position", o_image.position, 32'h0000_0070);
		chk("status", o_image.status, 32'h0);
		$display("reset test done");
		@(posedge i_clock);
		i_crc_bad <= 1'b1;
		tick(2);
		chk("crc fault", o_image.status & 32'h8000, 32'h8000);
		$display("crc test done");
		wrap_up();
	end
endmodule // position_io_command_status_bench
